// ---- rsie_channel.sv ----
// rsie_channel: per-channel receive data holding, full/overflow/underflow/eof detection
// assumes bit strobes come from logic on i_clk
`timescale 1ns/1ps
`default_nettype none
module rsie_channel
  import rsie_pkg::*;
(
  // clock, reset and clock enable
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_ce,
  // receiver bit stream
  input  wire logic                      i_bit_tick,
  input  wire logic                      i_bit_valid,
  input  wire logic                      i_bit_data,
  input  wire logic [RSIE_EOF_LEN_W-1:0] i_eof_len,
  // host access
  input  wire logic                      i_data_rd,
  input  wire logic                      i_status_rd,
  // results
  output logic [7:0]                     o_data,
  output logic                           o_full_evt,
  output logic                           o_over_evt,
  output logic                           o_under_evt,
  output logic                           o_eof
);
  logic [7:0] shift;
  logic [3:0] nbits;
  logic [3:0] gap;
  logic       seen_valid;
  logic       fresh;
  logic       eof_hit;
  logic       byte_done;
  logic       load;

  // ----------------------------------------
  // frame tracking
  // ----------------------------------------
  assign byte_done = i_bit_tick && i_bit_valid && (nbits == 4'h7);
  // gap counts earlier invalid bits; eof once it reaches the programmed length
  assign eof_hit = i_bit_tick && !i_bit_valid && seen_valid &&
                   (gap >= {1'b0, i_eof_len});
  assign load = byte_done || (eof_hit && nbits != 4'h0);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shift      <= 8'h00;
      nbits      <= 4'h0;
      gap        <= 4'h0;
      seen_valid <= 1'b0;
    end else if (i_ce && i_bit_tick) begin
      if (i_bit_valid) begin
        // cleared after each load so a short final byte keeps zero high bits
        shift      <= byte_done ? 8'h00 : {shift[6:0], i_bit_data};
        nbits      <= byte_done ? 4'h0 : nbits + 4'h1;
        gap        <= 4'h0;
        seen_valid <= 1'b1;
      end else if (eof_hit) begin
        shift      <= 8'h00;
        nbits      <= 4'h0;
        gap        <= 4'h0;
        seen_valid <= 1'b0;
      end else if (seen_valid && gap != 4'hf) begin
        gap <= gap + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // data register and freshness
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_data <= 8'h00;
      fresh  <= 1'b0;
    end else if (i_ce) begin
      if (load) begin
        o_data <= byte_done ? {shift[6:0], i_bit_data} : shift;
        fresh  <= 1'b1; // load beats a same-cycle read
      end else if (i_data_rd) begin
        fresh <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // events and eof level
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_full_evt  <= 1'b0;
      o_over_evt  <= 1'b0;
      o_under_evt <= 1'b0;
      o_eof       <= 1'b0;
    end else if (i_ce) begin
      o_full_evt  <= load;
      o_over_evt  <= load && fresh && !i_data_rd;
      o_under_evt <= i_data_rd && !fresh && !load;
      // new eof wins over a same-cycle status read
      if (eof_hit) o_eof <= 1'b1;
      else if (i_status_rd) o_eof <= 1'b0;
    end
  end
endmodule : rsie_channel
`default_nettype wire

// ---- rsie_pkg.sv ----
// rsie_pkg: constants for the receive serdes interrupt enable block
// assumes the host reaches the enable register through the serial register port
package rsie_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [5:0] RSIE_ADDR_ENABLE  = 6'h07;
  localparam logic [5:0] RSIE_ADDR_STATUS  = 6'h08;
  localparam logic [5:0] RSIE_ADDR_DATA_A  = 6'h09;
  localparam logic [5:0] RSIE_ADDR_DATA_B  = 6'h0b;
  localparam logic [7:0] RSIE_ENABLE_RESET = 8'h00;
  // ----------------------------------------
  // enable bit positions and eof length width
  // ----------------------------------------
  localparam int RSIE_BIT_UNDER_B = 7;
  localparam int RSIE_BIT_OVER_B  = 6;
  localparam int RSIE_BIT_EOF_B   = 5;
  localparam int RSIE_BIT_FULL_B  = 4;
  localparam int RSIE_BIT_UNDER_A = 3;
  localparam int RSIE_BIT_OVER_A  = 2;
  localparam int RSIE_BIT_EOF_A   = 1;
  localparam int RSIE_BIT_FULL_A  = 0;
  localparam int RSIE_EOF_LEN_W   = 3;
endpackage : rsie_pkg

// ---- rsie_rx_model.sv ----
// rsie_rx_model: bit source standing in for the two receivers
// assumes send_bit is called from one process only
`timescale 1ns/1ps
`default_nettype none
module rsie_rx_model (
  input  wire logic       i_clk,
  output var  logic [1:0] o_bit_tick,
  output var  logic [1:0] o_bit_valid,
  output var  logic [1:0] o_bit_data
);
  initial {o_bit_tick, o_bit_valid, o_bit_data} = 6'h00;
  // lines flip between strobes so nothing leans on a stale bit
  task send_bit(input int ch, input logic ok, input logic d);
    @(posedge i_clk);
    {o_bit_tick[ch], o_bit_valid[ch], o_bit_data[ch]} <= {1'b1, ok, d};
    @(posedge i_clk);
    {o_bit_tick[ch], o_bit_valid[ch], o_bit_data[ch]} <= {1'b0, !ok, !d};
  endtask : send_bit
endmodule : rsie_rx_model
`default_nettype wire

// ---- rsie_top.sv ----
// rsie_top: receive serdes interrupt enable register and interrupt gating
// assumes a register port decoder supplies single-cycle read/write strobes on i_clk
// What this block does
// - enable bit 7 gates channel B underflow onto the interrupt request.
// - reading channel B data register is where underflow is detected.
// - enable bit 6 gates channel B overflow onto the interrupt request.
// - overflow when new data loads before previous contents were read.
// - enable bit 5 gates channel B end of frame onto interrupt.
// - end-of-frame request stays asserted until the receive status register is read.
// - end of frame after a valid bit, once invalid bits exceed length.
// - length zero gives end of frame on first invalid bit.
// - reading the receive status register clears end of frame.
// - enable bit 4 gates channel B full event onto interrupt.
// - full event on every transfer into data register, partial bytes too.
// - end of frame moves pending received bits into data register.
`timescale 1ns/1ps
`default_nettype none
module rsie_top
  import rsie_pkg::*;
(
  // clock, reset, enable
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_ce,
  // register port
  input  wire logic [5:0]                i_reg_addr,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  input  wire logic [7:0]                i_reg_wdata,
  output logic [7:0]                     o_reg_rdata,
  // receivers
  input  wire logic [RSIE_EOF_LEN_W-1:0] i_eof_len,
  input  wire logic [1:0]                i_bit_tick,
  input  wire logic [1:0]                i_bit_valid,
  input  wire logic [1:0]                i_bit_data,
  // interrupt
  output logic                           o_irq,
  output logic [1:0]                     o_eof
);
  logic [7:0] enable;
  logic [1:0] full_evt;
  logic [1:0] over_evt;
  logic [1:0] under_evt;
  logic [7:0] data_q [2];
  logic [1:0] data_rd;
  logic       status_rd;
  logic [7:0] pend;

  assign status_rd  = i_reg_rd && (i_reg_addr == RSIE_ADDR_STATUS);
  assign data_rd[0] = i_reg_rd && (i_reg_addr == RSIE_ADDR_DATA_A);
  assign data_rd[1] = i_reg_rd && (i_reg_addr == RSIE_ADDR_DATA_B);

  // ----------------------------------------
  // channels: index 0 is A, 1 is B
  // ----------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_ch
    rsie_channel u_ch (
      .i_clk       (i_clk),
      .i_reset_n   (i_reset_n),
      .i_ce        (i_ce),
      .i_bit_tick  (i_bit_tick[c]),
      .i_bit_valid (i_bit_valid[c]),
      .i_bit_data  (i_bit_data[c]),
      .i_eof_len   (i_eof_len),
      .i_data_rd   (data_rd[c]),
      .i_status_rd (status_rd),
      .o_data      (data_q[c]),
      .o_full_evt  (full_evt[c]),
      .o_over_evt  (over_evt[c]),
      .o_under_evt (under_evt[c]),
      .o_eof       (o_eof[c])
    );
  end

  // ----------------------------------------
  // enable register
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      enable <= RSIE_ENABLE_RESET;
    end else if (i_ce && i_reg_wr && i_reg_addr == RSIE_ADDR_ENABLE) begin
      enable <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_ce && i_reg_rd) begin
      unique case (i_reg_addr)
        RSIE_ADDR_ENABLE: o_reg_rdata <= enable;
        RSIE_ADDR_DATA_A: o_reg_rdata <= data_q[0];
        RSIE_ADDR_DATA_B: o_reg_rdata <= data_q[1];
        default:          o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // interrupt gating
  // ----------------------------------------
  // events are one-cycle pulses; the status register that latches them lives elsewhere
  always_comb begin
    pend = 8'h00;
    pend[RSIE_BIT_UNDER_B] = under_evt[1] & enable[RSIE_BIT_UNDER_B];
    pend[RSIE_BIT_OVER_B]  = over_evt[1]  & enable[RSIE_BIT_OVER_B];
    pend[RSIE_BIT_EOF_B]   = o_eof[1]     & enable[RSIE_BIT_EOF_B];
    pend[RSIE_BIT_FULL_B]  = full_evt[1]  & enable[RSIE_BIT_FULL_B];
    pend[RSIE_BIT_UNDER_A] = under_evt[0] & enable[RSIE_BIT_UNDER_A];
    pend[RSIE_BIT_OVER_A]  = over_evt[0]  & enable[RSIE_BIT_OVER_A];
    pend[RSIE_BIT_EOF_A]   = o_eof[0]     & enable[RSIE_BIT_EOF_A];
    pend[RSIE_BIT_FULL_A]  = full_evt[0]  & enable[RSIE_BIT_FULL_A];
  end

  assign o_irq = |pend;
endmodule : rsie_top
`default_nettype wire

// ---- rsie_top_checker.sv ----
// rsie_top_checker: port-level assertions for the enable block
// assumes it is bound to rsie_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module rsie_top_checker import rsie_pkg::*; (
  input wire logic                      i_clk, i_reset_n, i_ce, i_reg_wr, i_reg_rd, o_irq,
  input wire logic [5:0]                i_reg_addr,
  input wire logic [7:0]                i_reg_wdata, o_reg_rdata,
  input wire logic [RSIE_EOF_LEN_W-1:0] i_eof_len,
  input wire logic [1:0]                i_bit_tick, i_bit_valid, i_bit_data, o_eof
);
  logic [7:0] en;
  logic       st_rd;
  logic       bad_b;
  assign st_rd = i_ce && i_reg_rd && i_reg_addr == RSIE_ADDR_STATUS;
  assign bad_b = i_ce && i_bit_tick[1] && !i_bit_valid[1];
  // shadow of the enable register, so masking can be judged from the ports
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) en <= RSIE_ENABLE_RESET;
    else if (i_ce && i_reg_wr && i_reg_addr == RSIE_ADDR_ENABLE) en <= i_reg_wdata;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_clr;
    st_rd && i_bit_tick == 2'b00;
  endsequence
  AST_EN_RD: assert property (i_ce && i_reg_rd && !i_reg_wr && i_reg_addr == RSIE_ADDR_ENABLE
    |=> o_reg_rdata == $past(en)) else $error("readback");
  AST_ST_RD: assert property (st_rd |=> o_reg_rdata == 8'h00) else $error("status data");
  AST_IRQ_OFF: assert property (en == 8'h00 |-> !o_irq) else $error("masked irq");
  AST_EOF_IRQ: assert property (o_eof[1] && en[RSIE_BIT_EOF_B] |-> o_irq) else $error("eof irq");
  AST_EOF_CLR: assert property (s_clr |=> o_eof == 2'b00) else $error("eof clear");
  AST_EOF_HOLD: assert property (o_eof[1] && !st_rd |=> o_eof[1]) else $error("eof drop");
  AST_EOF_RISE: assert property ($rose(o_eof[1]) |-> $past(bad_b)) else $error("eof rise");
  AST_EOF_QUIET: assert property (!o_eof[1] && !bad_b |=> !o_eof[1]) else $error("eof set");
  AST_CE_HOLD: assert property (!i_ce |=> $stable(o_reg_rdata) && $stable(o_eof))
    else $error("state moved while clock enable low");
endmodule : rsie_top_checker
bind rsie_top rsie_top_checker u_chk (.i_clk, .i_reset_n, .i_ce, .i_reg_wr, .i_reg_rd, .o_irq,
  .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_eof_len, .i_bit_tick, .i_bit_valid, .i_bit_data,
  .o_eof);
`default_nettype wire

// ---- test_rx_serdes_irq_enable.sv ----
// test_rx_serdes_irq_enable: directed bench for the enable block
// assumes rsie_rx_model supplies the receiver bit strobes
`timescale 1ns/1ps
`default_nettype none
module test_rx_serdes_irq_enable import rsie_pkg::*; ();
  localparam logic [5:0] EN = RSIE_ADDR_ENABLE;
  localparam logic [5:0] DB = RSIE_ADDR_DATA_B;
  logic       clk, reset_n, ce, wr, rd, irq;
  logic [5:0] addr;
  logic [7:0] wdata, rdata;
  logic [2:0] eof_len;
  logic [1:0] tick, valid, dat, eof;
  int         miscompares = 0, checked = 0, irqs = 0, base = 0;
  rsie_top uut (.i_clk(clk), .i_reset_n(reset_n), .i_ce(ce), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_eof_len(eof_len), .i_bit_tick(tick), .i_bit_valid(valid), .i_bit_data(dat),
    .o_irq(irq), .o_eof(eof));
  rsie_rx_model rx (.i_clk(clk), .o_bit_tick(tick), .o_bit_valid(valid), .o_bit_data(dat));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // d is write data, or the expected read data when w is low
  task automatic op(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, rd, addr, wdata} <= {w, !w, a, d};
    @(posedge clk);
    {wr, rd} <= 2'b00;
    #1;
    if (!w) check(rdata, d);
  endtask : op
  task automatic send(input int ch, input logic [7:0] v, input int n, input logic ok);
    for (int i = n - 1; i >= 0; i--) rx.send_bit(ch, ok, v[i]);
    repeat (2) @(posedge clk);
    #1;
  endtask : send
  task automatic irq_count(input logic [7:0] n);
    // let the negedge counter see a pulse launched by the last strobe
    @(posedge clk);
    #1;
    check(8'(irqs - base), n);
    base = irqs;
  endtask : irq_count
  task automatic wrap_up;
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // negedge sampling sees one-cycle pulses without racing the edge
  always @(negedge clk) if (irq === 1'b1) irqs++;
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    {reset_n, ce, wr, rd, addr, wdata, eof_len} = '0;
    repeat (10) @(posedge clk);
    {reset_n, ce} <= 2'b11;
    op(1'b0, EN, RSIE_ENABLE_RESET);
    op(1'b1, EN, 8'hff);
    op(1'b0, EN, 8'hff);
    op(1'b0, 6'h3f, 8'h00);
    ce <= 1'b0;
    op(1'b1, EN, 8'h55);
    ce <= 1'b1;
    op(1'b0, EN, 8'hff);
    op(1'b1, EN, 8'h00);
    base = irqs;
    send(1, 8'ha5, 8, 1'b1);
    op(1'b0, DB, 8'ha5);
    op(1'b0, DB, 8'ha5);
    irq_count(8'h00);
    op(1'b1, EN, 8'h10);
    send(1, 8'h3c, 8, 1'b1);
    irq_count(8'h01);
    op(1'b1, EN, 8'h40);
    send(1, 8'hc3, 8, 1'b1);
    irq_count(8'h01);
    op(1'b1, EN, 8'h80);
    op(1'b0, DB, 8'hc3);
    op(1'b0, DB, 8'hc3);
    irq_count(8'h01);
    op(1'b1, EN, 8'h0c);
    send(0, 8'h11, 8, 1'b1);
    send(0, 8'h22, 8, 1'b1);
    op(1'b0, RSIE_ADDR_DATA_A, 8'h22);
    op(1'b0, RSIE_ADDR_DATA_A, 8'h22);
    irq_count(8'h02);
    op(1'b1, EN, 8'h20);
    for (int len = 0; len <= 2; len += 2) begin
      @(posedge clk);
      eof_len <= 3'(len);
      send(1, 8'h05, 3, 1'b1);
      send(1, 8'h00, len, 1'b0);
      check({6'h00, eof}, 8'h00);
      send(1, 8'h00, 1, 1'b0);
      check({5'h00, eof, irq}, 8'h05);
      op(1'b0, DB, 8'h05);
      op(1'b0, RSIE_ADDR_STATUS, 8'h00);
      check({5'h00, eof, irq}, 8'h00);
    end
    wrap_up();
  end
endmodule : test_rx_serdes_irq_enable
`default_nettype wire
